// ---- src/frmc_host.sv ----
/*
  Host controller for an asynchronous SRAM-compatible 32K x 8 memory.
  Takes one request at a time from user logic and drives the memory pins
  with counted timing. Assumes the memory is the only load on its pins and
  that the data bus is resolved outside from dq_oe_o.
*/
`timescale 1ns/1ps
`default_nettype none
module frmc_host
   import frmc_pkg::*;
#(
   parameter int POWERUP_CYCLES = CYC_POWERUP
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // User request side
   input wire logic req_valid_i,
   input wire frmc_req_t req_i,
   output logic req_ready_o,
   output logic rsp_valid_o,
   output logic [DATA_W-1:0] rsp_rdata_o,
   // Memory pins
   output logic mem_ce_n_o,
   output logic mem_we_n_o,
   output logic mem_oe_n_o,
   output logic [ADDR_W-1:0] mem_addr_o,
   output logic [DATA_W-1:0] mem_dq_o,
   output logic mem_dq_oe_o,
   input wire logic [DATA_W-1:0] mem_dq_i
);

   // ==================================================================
   // State
   typedef struct packed {
      frmc_state_t st;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] ce_low;
      logic write;
      logic ready;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
      frmc_pins_t pins;
      logic [DATA_W-1:0] dq_s1;
      logic [DATA_W-1:0] dq_s2;
   } frmc_host_state_t;

   frmc_host_state_t state_reg;
   frmc_host_state_t state_next;

   function automatic logic [CNT_W-1:0] cyc(input int n);
      return CNT_W'(n);
   endfunction : cyc

   // ==================================================================
   // Next state
   always_comb begin
      state_next = state_reg;
      state_next.rvalid = 1'b0;
      // Read data passes two flops before use: it comes from off-chip
      state_next.dq_s1 = mem_dq_i;
      state_next.dq_s2 = state_reg.dq_s1;
      if (state_reg.cnt != CNT_ZERO) begin
         state_next.cnt = state_reg.cnt - CNT_ONE;
      end
      if (!state_reg.pins.ce_n && state_reg.ce_low != {CNT_W{1'b1}}) begin
         state_next.ce_low = state_reg.ce_low + CNT_ONE;
      end
      unique case (state_reg.st)
         ST_POWERUP: begin
            // No access until the supply has settled
            if (state_reg.cnt == CNT_ZERO) begin
               state_next.st = ST_IDLE;
               state_next.ready = 1'b1;
            end
         end
         ST_IDLE: begin
            if (req_valid_i) begin
               // Address and chip enable together: zero setup is allowed
               state_next.ready = 1'b0;
               state_next.write = req_i.write;
               // Any column order is taken; the address holds for the whole access
               state_next.pins.addr = req_i.addr;
               state_next.pins.ce_n = 1'b0;
               state_next.ce_low = CNT_ZERO;
               state_next.pins.oe_n = req_i.write;
               state_next.pins.dq_out = req_i.wdata;
               state_next.pins.dq_oe = 1'b0;
               state_next.st = ST_ACCESS;
               state_next.cnt = cyc(CYC_ADDR_HOLD);
            end
         end
         ST_ACCESS: begin
            if (state_reg.write) begin
               // WE-controlled write: the cycle opens with WE and OE high, then WE pulses
               state_next.st = ST_WSETUP;
               state_next.pins.dq_oe = 1'b1;
               state_next.cnt = cyc(CYC_PAGE_ASETUP);
            end else begin
               state_next.st = ST_RDWAIT;
               state_next.cnt = cyc(CYC_CE_ACCESS);
            end
         end
         ST_RDWAIT: begin
            // Hold CE at least its active time; data valid by access time
            if (state_reg.cnt == CNT_ZERO
                && state_reg.ce_low >= cyc(CYC_CE_ACTIVE)
                && state_reg.ce_low >= cyc(CYC_ADDR_HOLD)) begin
               state_next.rdata = state_reg.dq_s2;
               state_next.rvalid = 1'b1;
               state_next.pins.ce_n = 1'b1;
               state_next.pins.oe_n = 1'b1;
               state_next.st = ST_PRECHG;
               state_next.cnt = cyc(CYC_PRECHARGE);
            end
         end
         ST_WSETUP: begin
            if (state_reg.cnt == CNT_ZERO) begin
               state_next.pins.we_n = 1'b0;
               state_next.st = ST_WPULSE;
               state_next.cnt = cyc(CYC_WE_PULSE);
            end
         end
         ST_WPULSE: begin
            // WE rises first, so it terminates the write and captures data
            if (state_reg.cnt == CNT_ZERO
                && state_reg.ce_low >= cyc(CYC_CE_TO_WEH)
                && state_reg.ce_low >= cyc(CYC_ROW_TO_WEH)
                && state_reg.ce_low >= cyc(CYC_CE_ACTIVE + CYC_DATA_SETUP)) begin
               state_next.pins.we_n = 1'b1;
               // One pulse per access, so pulses sit at least nine cycles apart
               state_next.st = ST_PRECHG;
               state_next.cnt = cyc(CYC_WEL_TO_CEH);
            end
         end
         ST_PRECHG: begin
            // WE went high above; CE follows one cycle later, data held to it
            if (!state_reg.pins.ce_n) begin
               state_next.pins.ce_n = 1'b1;
               state_next.pins.dq_oe = 1'b0;
               state_next.cnt = cyc(CYC_PRECHARGE);
            end else if (state_reg.cnt == CNT_ZERO) begin
               // Standby: CE high, other pins are don't-care to the memory
               state_next.st = ST_IDLE;
               state_next.ready = 1'b1;
            end
         end
         default: begin
            state_next.st = ST_IDLE;
         end
      endcase
   end

   // ==================================================================
   // Registers
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         state_reg.st <= ST_POWERUP;
         state_reg.cnt <= CNT_W'(POWERUP_CYCLES);
         state_reg.ce_low <= CNT_ZERO;
         state_reg.write <= 1'b0;
         state_reg.ready <= 1'b0;
         state_reg.rvalid <= 1'b0;
         state_reg.rdata <= '0;
         state_reg.pins.ce_n <= 1'b1;
         state_reg.pins.we_n <= 1'b1;
         state_reg.pins.oe_n <= 1'b1;
         state_reg.pins.addr <= '0;
         state_reg.pins.dq_out <= '0;
         state_reg.pins.dq_oe <= 1'b0;
         state_reg.dq_s1 <= '0;
         state_reg.dq_s2 <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ==================================================================
   // Outputs straight from flops
   assign req_ready_o = state_reg.ready;
   assign rsp_valid_o = state_reg.rvalid;
   assign rsp_rdata_o = state_reg.rdata;
   assign mem_ce_n_o = state_reg.pins.ce_n;
   assign mem_we_n_o = state_reg.pins.we_n;
   assign mem_oe_n_o = state_reg.pins.oe_n;
   assign mem_addr_o = state_reg.pins.addr;
   assign mem_dq_o = state_reg.pins.dq_out;
   assign mem_dq_oe_o = state_reg.pins.dq_oe;

endmodule : frmc_host
`default_nettype wire

// ---- src/frmc_pkg.sv ----
/*
  Constants and carrier types for the host-side controller of an
  asynchronous SRAM-compatible 32K x 8 nonvolatile memory.
  Assumes a 40 MHz core clock; all pin timing is counted in cycles of it.
*/
package frmc_pkg;

   // ==================================================================
   // Clock and timing
   localparam int CLK_PERIOD_PS = 25000;
   localparam int T_CE_ACCESS_NS = 70;
   localparam int T_CE_ACTIVE_NS = 70;
   localparam int T_ADDR_HOLD_NS = 70;
   localparam int T_PAGE_ACCESS_NS = 40;
   localparam int T_PAGE_STABLE_NS = 15;
   localparam int T_WE_PULSE_NS = 18;
   localparam int T_CE_TO_WEH_NS = 70;
   localparam int T_DATA_SETUP_NS = 15;
   localparam int T_PAGE_WCYCLE_NS = 35;
   localparam int T_PAGE_ASETUP_NS = 5;
   localparam int T_PAGE_AHOLD_NS = 20;
   localparam int T_WEL_TO_CEH_NS = 25;
   localparam int T_ROW_TO_WEH_NS = 140;
   localparam int T_PRECHARGE_NS = 70;
   localparam int T_OE_HIZ_NS = 10;
   localparam int T_POWERUP_US = 250;

   // Least times round up to whole cycles, never below one
   function automatic int ns_cycles(input int ns);
      int c;
      c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction : ns_cycles

   localparam int CYC_CE_ACCESS = ns_cycles(T_CE_ACCESS_NS) + 1; // One extra for sampling
   localparam int CYC_CE_ACTIVE = ns_cycles(T_CE_ACTIVE_NS);
   localparam int CYC_ADDR_HOLD = ns_cycles(T_ADDR_HOLD_NS);
   localparam int CYC_PAGE_ACCESS = ns_cycles(T_PAGE_ACCESS_NS) + 1;
   localparam int CYC_PAGE_STABLE = ns_cycles(T_PAGE_STABLE_NS);
   localparam int CYC_WE_PULSE = ns_cycles(T_WE_PULSE_NS);
   localparam int CYC_CE_TO_WEH = ns_cycles(T_CE_TO_WEH_NS);
   localparam int CYC_DATA_SETUP = ns_cycles(T_DATA_SETUP_NS);
   localparam int CYC_PAGE_WCYCLE = ns_cycles(T_PAGE_WCYCLE_NS);
   localparam int CYC_PAGE_ASETUP = ns_cycles(T_PAGE_ASETUP_NS);
   localparam int CYC_PAGE_AHOLD = ns_cycles(T_PAGE_AHOLD_NS);
   localparam int CYC_WEL_TO_CEH = ns_cycles(T_WEL_TO_CEH_NS);
   localparam int CYC_ROW_TO_WEH = ns_cycles(T_ROW_TO_WEH_NS);
   localparam int CYC_PRECHARGE = ns_cycles(T_PRECHARGE_NS);
   localparam int CYC_OE_HIZ = ns_cycles(T_OE_HIZ_NS);
   localparam int CYC_POWERUP = (T_POWERUP_US * 1000 * 1000) / CLK_PERIOD_PS;

   // ==================================================================
   // Widths and fields
   localparam int ADDR_W = 15;
   localparam int COL_W = 3;
   localparam int ROW_W = ADDR_W - COL_W;
   localparam int DATA_W = 8;
   localparam int CNT_W = 16;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

   // ==================================================================
   // Types
   typedef enum logic [6:0] {
      ST_POWERUP = 7'h01,
      ST_IDLE    = 7'h02,
      ST_ACCESS  = 7'h04,
      ST_RDWAIT  = 7'h08,
      ST_WSETUP  = 7'h10,
      ST_WPULSE  = 7'h20,
      ST_PRECHG  = 7'h40
   } frmc_state_t;

   // Request from user logic: one byte read or write
   typedef struct packed {
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } frmc_req_t;

   // Pins toward the memory; data is split into out and enable, input is a separate port
   typedef struct packed {
      logic ce_n;
      logic we_n;
      logic oe_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq_out;
      logic dq_oe;
   } frmc_pins_t;

endpackage : frmc_pkg

// ---- tb/frmc_host_props.sv ----
/* Pin timing checker for frmc_host.
   Sees only the top ports; bound to every frmc_host at the foot. */
`timescale 1ns/1ps
`default_nettype none
module frmc_host_props
   import frmc_pkg::*;
#(parameter int POWERUP_CYCLES = 20) (
   // Watched ports
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic rsp_valid_o,
   input wire logic mem_ce_n_o,
   input wire logic mem_we_n_o,
   input wire logic mem_oe_n_o,
   input wire logic [ADDR_W-1:0] mem_addr_o,
   input wire logic [DATA_W-1:0] mem_dq_o,
   input wire logic mem_dq_oe_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   // ================================================================
   // Helpers: cycles since reset, cycles of chip enable low (saturating)
   logic [CNT_W-1:0] up_cnt;
   logic [7:0] ce_low;
   always_ff @(posedge core_clk_i) begin
      up_cnt <= sys_rst_i ? CNT_ZERO : ((&up_cnt) ? up_cnt : up_cnt + CNT_ONE);
      ce_low <= mem_ce_n_o ? 8'h00 : ((&ce_low) ? ce_low : ce_low + 8'h01);
   end
   // ================================================================
   // Properties
   property p_ce_active; $fell(mem_ce_n_o) |-> !mem_ce_n_o [*3]; endproperty
   a_ce_active: assert property (p_ce_active) else $error("chip enable low too short");
   property p_precharge; $rose(mem_ce_n_o) |-> mem_ce_n_o [*3]; endproperty
   a_precharge: assert property (p_precharge) else $error("pre-charge too short");
   property p_addr_hold; !mem_ce_n_o && $past(!mem_ce_n_o) |-> $stable(mem_addr_o); endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address moved in access");
   // Row is set when chip enable falls, so 140 ns counts from there
   property p_row_to_weh; $rose(mem_we_n_o) |-> !mem_ce_n_o && ce_low >= 8'h06; endproperty
   a_row_to_weh: assert property (p_row_to_weh) else $error("write ended early");
   property p_data_setup;
      $rose(mem_we_n_o) |-> mem_dq_oe_o && $past(mem_dq_oe_o) && $stable(mem_dq_o);
   endproperty
   a_data_setup: assert property (p_data_setup) else $error("write data not set up");
   property p_we_in_ce; !mem_we_n_o |-> !mem_ce_n_o; endproperty
   a_we_in_ce: assert property (p_we_in_ce) else $error("write strobe outside access");
   property p_we_pulse; $fell(mem_we_n_o) |-> !mem_ce_n_o throughout !mem_we_n_o [*1]; endproperty
   a_we_pulse: assert property (p_we_pulse) else $error("write strobe too short");
   // Host never drives the bus while the device may be driving it
   property p_no_fight; mem_dq_oe_o |-> mem_oe_n_o; endproperty
   a_no_fight: assert property (p_no_fight) else $error("bus driven during read");
   property p_read_wait; $fell(mem_oe_n_o) |-> !rsp_valid_o [*3] ##[1:12] rsp_valid_o; endproperty
   a_read_wait: assert property (p_read_wait) else $error("read answer mistimed");
   property p_powerup; !mem_ce_n_o |-> up_cnt >= POWERUP_CYCLES; endproperty
   a_powerup: assert property (p_powerup) else $error("access before power-up wait");
endmodule : frmc_host_props
bind frmc_host frmc_host_props #(.POWERUP_CYCLES(POWERUP_CYCLES)) frmc_host_props_inst (
   .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .rsp_valid_o(rsp_valid_o),
   .mem_ce_n_o(mem_ce_n_o), .mem_we_n_o(mem_we_n_o), .mem_oe_n_o(mem_oe_n_o),
   .mem_addr_o(mem_addr_o), .mem_dq_o(mem_dq_o), .mem_dq_oe_o(mem_dq_oe_o));
`default_nettype wire

// ---- tb/frmc_mem_model.sv ----
/* Behavioural 32K x 8 memory seen from its pins.
   Assumes the bench resolves the shared data bus from both sides. */
`timescale 1ns/1ps
`default_nettype none
module frmc_mem_model
   import frmc_pkg::*;
(
   // Memory pins
   input wire logic ce_n_i,
   input wire logic we_n_i,
   input wire logic oe_n_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] dq_i,
   output logic [DATA_W-1:0] dq_o
);
   logic [DATA_W-1:0] mem [0:32767];
   realtime t_fall = 0.0;
   // ================================================================
   // Access start, for the access delay
   always @(negedge ce_n_i) t_fall = $realtime;
   // Byte latched on whichever enable rises first; standby ignores strobes
   always @(posedge we_n_i) if (!ce_n_i) mem[addr_i] = dq_i;
   always @(posedge ce_n_i) if (!we_n_i) mem[addr_i] = dq_i;
   // Any address order reads; off the bus dq_o inverts every 1 ns,
   // so it alternates between the stale byte and its inverse
   initial dq_o = 8'h00;
   always #1 begin
      if (!ce_n_i && !oe_n_i && we_n_i && $realtime - t_fall >= T_CE_ACCESS_NS)
         dq_o = mem[addr_i];
      else
         dq_o = ~dq_o;
   end
endmodule : frmc_mem_model
`default_nettype wire

// ---- tb/tb.sv ----
/* Self-checking bench: frmc_host driving the memory model.
   Assumes 40 MHz and a short power-up count of PU cycles. */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import frmc_pkg::*;
   localparam int PU = 20;
   logic core_clk_i, sys_rst_i, req_valid_i, req_ready_o, rsp_valid_o, ce_n, we_n, oe_n, dq_oe;
   frmc_req_t req_i;
   logic [DATA_W-1:0] rsp_rdata_o, host_dq, dev_dq, bus;
   logic [ADDR_W-1:0] addr;
   int num_errors = 0;
   int check_count = 0;
   // Shared data bus: host side while it drives, else the device side
   assign bus = dq_oe ? host_dq : dev_dq;
   frmc_host #(.POWERUP_CYCLES(PU)) frmc_host_inst (.core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i), .req_valid_i(req_valid_i), .req_i(req_i),
      .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
      .mem_ce_n_o(ce_n), .mem_we_n_o(we_n), .mem_oe_n_o(oe_n), .mem_addr_o(addr),
      .mem_dq_o(host_dq), .mem_dq_oe_o(dq_oe), .mem_dq_i(bus));
   frmc_mem_model frmc_mem_model_inst (.ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n),
      .addr_i(addr), .dq_i(bus), .dq_o(dev_dq));
   initial begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end
   // ================================================================
   // Shared tasks
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : tally_and_finish
   // Bounded wait, sampled at the falling edge where outputs are settled
   task automatic wait_hi(ref logic s);
      int n;
      n = 0;
      do begin
         @(negedge core_clk_i);
         n++;
      end while (s !== 1'b1 && n < 400);
      if (s !== 1'b1) begin
         num_errors++;
         tally_and_finish();
      end
   endtask : wait_hi
   // Request held until the edge that sees ready high takes it
   task automatic send(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge core_clk_i);
      req_valid_i <= 1'b1;
      req_i <= '{write: w, addr: a, wdata: d};
      wait_hi(req_ready_o);
      @(posedge core_clk_i);
      req_valid_i <= 1'b0;
   endtask : send
   task automatic read_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      send(1'b0, a, 8'h00);
      wait_hi(rsp_valid_o);
      check({8'h00, rsp_rdata_o}, {8'h00, exp});
   endtask : read_chk
   // ================================================================
   // Scenarios
   task automatic sc_powerup;
      int n;
      n = 0;
      while (req_ready_o !== 1'b1 && n < 100) begin
         @(negedge core_clk_i);
         n++;
      end
      check({15'h0000, n >= PU}, 16'h0001);
      check({15'h0000, ce_n}, 16'h0001);
   endtask : sc_powerup
   // Boundary and cross-row addresses, written then read back to back
   task automatic sc_write_read;
      logic [ADDR_W-1:0] tbl [5] = '{15'h0000, 15'h7fff, 15'h0008, 15'h0007, 15'h4aa5};
      for (int i = 0; i < 5; i++) send(1'b1, tbl[i], 8'h5a ^ 8'(i * 37));
      for (int i = 0; i < 5; i++) read_chk(tbl[i], 8'h5a ^ 8'(i * 37));
   endtask : sc_write_read
   // One row, columns read back out of order
   task automatic sc_col_order;
      int cols [8] = '{5, 2, 7, 0, 3, 6, 1, 4};
      for (int i = 0; i < 8; i++) send(1'b1, {12'h123, 3'(i)}, 8'h30 + 8'(i));
      for (int i = 0; i < 8; i++) read_chk({12'h123, 3'(cols[i])}, 8'h30 + 8'(cols[i]));
   endtask : sc_col_order
   // Request raised while busy must be dropped; overwrite must land
   task automatic sc_refused;
      send(1'b1, 15'h7fff, 8'h11);
      @(posedge core_clk_i);
      req_valid_i <= 1'b1;
      req_i <= '{write: 1'b1, addr: 15'h0000, wdata: 8'hee};
      @(posedge core_clk_i);
      req_valid_i <= 1'b0;
      read_chk(15'h0000, 8'h5a);
      read_chk(15'h7fff, 8'h11);
   endtask : sc_refused
   // ================================================================
   // Main sequence and hang guard
   initial begin
      sys_rst_i = 1'b1;
      req_valid_i = 1'b0;
      req_i = '0;
      repeat (12) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      sc_powerup();
      sc_write_read();
      sc_col_order();
      sc_refused();
      tally_and_finish();
   end
   initial begin
      repeat (20000) @(posedge core_clk_i);
      num_errors++;
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
